/* File: testbench/core_model.sv */
// core-side model: turns each bench request into one registered access
// assumes requests change right after a rising edge of clk
`timescale 1ns/1ps
module core_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // request from the bench
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire bdu_pkg::acc_kind_t req_kind,
   input wire bdu_pkg::bp_len_t req_size,
   input wire logic req_switch,
   // access lines to the unit
   output logic acc_valid,
   output logic [31:0] acc_addr,
   output bdu_pkg::acc_kind_t acc_kind,
   output bdu_pkg::bp_len_t acc_size,
   output logic task_switch
);
   // idle lines toggle, so a stale access can never pass for a real one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_valid <= 1'b0;
         acc_addr <= 32'h0;
         acc_kind <= bdu_pkg::ACC_FETCH;
         acc_size <= bdu_pkg::LEN_1;
         task_switch <= 1'b0;
      end else begin
         acc_valid <= req_valid;
         task_switch <= req_switch;
         acc_addr <= req_valid ? req_addr : ~acc_addr;
         acc_kind <= req_valid ? req_kind : bdu_pkg::acc_kind_t'(~acc_kind);
         acc_size <= req_valid ? req_size : bdu_pkg::bp_len_t'(~acc_size);
      end
   end
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench of the breakpoint debug unit
// assumes the unit answers the bus with zero wait states and the core model upstream
`timescale 1ns/1ps
`include "bdu_defs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
   localparam bdu_pkg::acc_kind_t F = bdu_pkg::ACC_FETCH;
   localparam bdu_pkg::acc_kind_t R = bdu_pkg::ACC_READ;
   localparam bdu_pkg::acc_kind_t W = bdu_pkg::ACC_WRITE;
   localparam bdu_pkg::bp_len_t S1 = bdu_pkg::LEN_1;
   localparam bdu_pkg::bp_len_t S2 = bdu_pkg::LEN_2;
   localparam bdu_pkg::bp_len_t S4 = bdu_pkg::LEN_4;
   typedef struct {
      logic [31:0] a;
      bdu_pkg::acc_kind_t k;
      bdu_pkg::bp_len_t s;
      logic x;
      logic [3:0] h;
   } row_t;
   row_t rows [10] = '{
      '{32'h1000, F, S1, 1'b1, 4'h1}, '{32'h1000, R, S1, 1'b0, 4'h0},
      '{32'h2003, W, S1, 1'b1, 4'h2}, '{32'h2002, R, S2, 1'b0, 4'h0},
      '{32'h2001, W, S1, 1'b0, 4'h0}, '{32'h3002, R, S1, 1'b1, 4'h4},
      '{32'h3000, W, S4, 1'b1, 4'h4}, '{32'h4001, W, S1, 1'b0, 4'h0},
      '{32'h1001, F, S1, 1'b0, 4'h0}, '{32'h1000, F, S4, 1'b1, 4'h1}};
   logic [31:0] bpa [4] = '{32'h1000, 32'h2002, 32'h3000, 32'h4001};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [3:0] hprot = 4'h3;
   logic [31:0] hwdata = 32'h0;
   logic req_valid = 1'b0;
   logic [31:0] req_addr = 32'h0;
   bdu_pkg::acc_kind_t req_kind = F;
   bdu_pkg::bp_len_t req_size = S1;
   logic req_switch = 1'b0;
   logic irq_on = 1'b0;
   logic [31:0] rd;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, acc_valid, task_switch, exc, exc_f, irq;
   wire logic [31:0] acc_addr;
   wire bdu_pkg::acc_kind_t acc_kind;
   wire bdu_pkg::bp_len_t acc_size;
   wire logic [3:0] hits;
   int failures = 0;
   int checked = 0;

   always #2 clk = ~clk;

   core_model i_core (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_addr(req_addr),
      .req_kind(req_kind), .req_size(req_size), .req_switch(req_switch),
      .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
      .acc_size(acc_size), .task_switch(task_switch));

   breakpoint_debug_unit i_dut (.REF_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HPROT(hprot), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .ACC_VALID(acc_valid), .ACC_ADDR(acc_addr), .ACC_KIND(acc_kind), .ACC_SIZE(acc_size),
      .TASK_SWITCH(task_switch), .DBG_EXC(exc), .DBG_EXC_FETCH(exc_f), .DBG_HITS(hits),
      .IRQ(irq));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic conclude;
      if (failures == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // one single transfer; a wait that never ends counts as a mismatch
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      n = 0;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 40);
      rd = hrdata;
      `CHK(hresp, 1'b0);
      if (n >= 40) begin
         failures++;
         conclude();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e);
   endtask

   task automatic acc(input row_t r);
      req_valid <= 1'b1;
      req_addr <= r.a;
      req_kind <= r.k;
      req_size <= r.s;
      @(posedge clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({exc, exc_f, hits}, {r.x, r.x & (r.k == F), r.h});
      @(posedge clk);
      `CHK(irq, r.x & irq_on);
   endtask

   task automatic pulse_switch;
      req_switch <= 1'b1;
      @(posedge clk);
      req_switch <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) rdchk(8'(4 * i), 32'h0);
      rdchk(`BDU_OFS_DCTRL, 32'h0000_0400);
      rdchk(`BDU_OFS_DSTAT, 32'h0000_0ff0);
      rdchk(8'h3c, 32'h0);
      for (int i = 0; i < 4; i++) wr(8'(4 * i), bpa[i]);
      for (int i = 0; i < 4; i++) rdchk(8'(4 * i), bpa[i]);
      wr(`BDU_OFS_DCTRL, 32'h2f50_00aa);
      rdchk(`BDU_OFS_DCTRL, 32'h2f50_04aa);
      wr(`BDU_OFS_IRQEN, 32'h3);
      irq_on = 1'b1;
      foreach (rows[i]) begin
         acc(rows[i]);
         wr(`BDU_OFS_IRQCLR, 32'h1);
      end
      // unused length and the no-access kind code never match
      wr(`BDU_OFS_DCTRL, 32'h0f58_002a);
      acc('{32'h1000, F, S1, 1'b0, 4'h0});
      acc('{32'h3000, bdu_pkg::acc_kind_t'(2'h3), S4, 1'b0, 4'h0});
      // disabled breakpoint on the same address still reports its hit
      wr(`BDU_OFS_BPADDR3, 32'h1000);
      wr(`BDU_OFS_DCTRL, 32'h0f50_002a);
      acc('{32'h1000, F, S1, 1'b1, 4'h9});
      wr(`BDU_OFS_DSTAT, 32'h0);
      rdchk(`BDU_OFS_DSTAT, 32'h0000_0ff9);
      rdchk(`BDU_OFS_IRQSTAT, 32'h1);
      wr(`BDU_OFS_IRQCLR, 32'h1);
      rdchk(`BDU_OFS_DSTAT, 32'h0000_0ff0);
      wr(`BDU_OFS_IRQEN, 32'h0);
      irq_on = 1'b0;
      acc('{32'h1000, F, S1, 1'b1, 4'h9});
      wr(`BDU_OFS_IRQCLR, 32'h1);
      wr(`BDU_OFS_IRQEN, 32'h3);
      irq_on = 1'b1;
      wr(`BDU_OFS_DCTRL, 32'h0000_0001);
      pulse_switch();
      rdchk(`BDU_OFS_DCTRL, 32'h0000_0400);
      acc('{32'h1000, F, S1, 1'b0, 4'h0});
      wr(`BDU_OFS_DCTRL, 32'h0000_0002);
      pulse_switch();
      rdchk(`BDU_OFS_DCTRL, 32'h0000_0402);
      acc('{32'h1000, F, S1, 1'b1, 4'h9});
      wr(`BDU_OFS_IRQCLR, 32'h1);
      // user-mode access is refused and flagged
      hprot <= 4'h1;
      wr(`BDU_OFS_BPADDR0, 32'hdead_beef);
      rdchk(`BDU_OFS_BPADDR0, 32'h0);
      hprot <= 4'h3;
      rdchk(`BDU_OFS_BPADDR0, 32'h1000);
      rdchk(`BDU_OFS_IRQSTAT, 32'h2);
      wr(`BDU_OFS_DCTRL, 32'h0000_2002);
      rdchk(`BDU_OFS_DCTRL, 32'h0);
      acc('{32'h1000, F, S1, 1'b1, 4'h9});
      rdchk(`BDU_OFS_DCTRL, 32'h0000_0402);
      // mid-run reset: hits and interrupt drop at once, registers return to reset values
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK({exc, exc_f, hits, irq}, 7'h0);
      rst_n <= 1'b1;
      @(posedge clk);
      rdchk(`BDU_OFS_IRQSTAT, 32'h0);
      rdchk(`BDU_OFS_BPADDR0, 32'h0);
      rdchk(`BDU_OFS_DCTRL, 32'h0000_0400);
      wr(`BDU_OFS_IRQCLR, 32'h3);
      rdchk(`BDU_OFS_IRQSTAT, 32'h0);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule

/* File: verilog/access_if.sv */
// carrier for one core access from the unit's front end to its comparators
// assumes a single clock; the signals are combinational within a cycle
`timescale 1ns/1ps
interface access_if;
   logic valid;
   logic [31:0] addr;
   bdu_pkg::acc_kind_t kind;
   bdu_pkg::bp_len_t size;

   modport src (output valid, output addr, output kind, output size);
   modport sink (input valid, input addr, input kind, input size);
endinterface

/* File: verilog/bdu_defs.svh */
// constants of the breakpoint debug unit: offsets, field positions, reset values
// assumes byte addressing on a 32-bit AHB-Lite bus, one register per aligned word
`ifndef BDU_DEFS_SVH
`define BDU_DEFS_SVH

// register byte offsets
`define BDU_OFS_BPADDR0 8'h00
`define BDU_OFS_BPADDR1 8'h04
`define BDU_OFS_BPADDR2 8'h08
`define BDU_OFS_BPADDR3 8'h0c
`define BDU_OFS_DSTAT 8'h10
`define BDU_OFS_DCTRL 8'h14
`define BDU_OFS_IRQSTAT 8'h18
`define BDU_OFS_IRQCLR 8'h1c
`define BDU_OFS_IRQEN 8'h20

// control register layout, breakpoint n adds 2n to enable, 4n to type and length
`define BDU_CTL_LOC 0
`define BDU_CTL_GLB 1
`define BDU_CTL_GD 13
`define BDU_CTL_TYPE 16
`define BDU_CTL_LEN 18
`define BDU_CTL_WMASK 32'hffff_20ff
`define BDU_CTL_ONES 32'h0000_0400
`define BDU_CTL_LOCMASK 32'h0000_0055

// status register: hit flags in the low bits, reserved ones above
`define BDU_STAT_ONES 32'h0000_0ff0

// interrupt status bits
`define BDU_IRQ_EXC 0
`define BDU_IRQ_REFUSED 1

// reset values
`define BDU_RST_ADDR 32'h0000_0000
`define BDU_RST_CTRL 32'h0000_0000
`define BDU_RST_STAT 4'h0

`endif

/* File: verilog/bdu_pkg.sv */
// types and shared decoding of the breakpoint debug unit
// assumes nothing beyond the constants header
package bdu_pkg;

   // kind of core access presented for comparison
   typedef enum logic [1:0] {
      ACC_FETCH = 2'h0,
      ACC_READ  = 2'h1,
      ACC_WRITE = 2'h2
   } acc_kind_t;

   // access type field encodings
   typedef enum logic [1:0] {
      BT_EXEC   = 2'h0,
      BT_WRITE  = 2'h1,
      BT_UNUSED = 2'h2,
      BT_RDWR   = 2'h3
   } bp_type_t;

   // target length field encodings, also used for the access size
   typedef enum logic [1:0] {
      LEN_1 = 2'h0,
      LEN_2 = 2'h1,
      LEN_X = 2'h2,
      LEN_4 = 2'h3
   } bp_len_t;

   // bytes touched inside the aligned word; unused code touches none
   function automatic logic [3:0] byte_mask(input logic [1:0] lo, input bp_len_t len);
      logic [3:0] m;
      m = 4'h0;
      unique case (len)
         LEN_1: m = 4'h1 << lo;
         LEN_2: m = lo[1] ? 4'hc : 4'h3;
         LEN_4: m = 4'hf;
         LEN_X: m = 4'h0;
      endcase
      return m;
   endfunction

endpackage

/* File: verilog/bp_compare.sv */
// one breakpoint comparator: address, access type and length against an access
// assumes accesses do not cross an aligned word; hit ignores the enables
`timescale 1ns/1ps
module bp_compare (
   // programmed breakpoint
   input wire logic [31:0] bp_addr,
   input wire bdu_pkg::bp_type_t bp_type,
   input wire bdu_pkg::bp_len_t bp_len,
   // access under test
   access_if.sink acc,
   // condition met
   output logic hit
);
   wire word_eq;
   wire overlap;
   wire kind_ok;
   wire [3:0] bp_bytes;
   wire [3:0] acc_bytes;

   assign word_eq = (bp_addr[31:2] == acc.addr[31:2]);
   // length decoding, unused code covers nothing
   assign bp_bytes = bdu_pkg::byte_mask(bp_addr[1:0], bp_len);
   assign acc_bytes = bdu_pkg::byte_mask(acc.addr[1:0], acc.size);
   assign overlap = |(bp_bytes & acc_bytes);

   // access type decoding; kind code 3 is no access and matches nothing
   assign kind_ok = (bp_type == bdu_pkg::BT_EXEC) ? (acc.kind == bdu_pkg::ACC_FETCH) :
                    (bp_type == bdu_pkg::BT_WRITE) ? (acc.kind == bdu_pkg::ACC_WRITE) :
                    (bp_type == bdu_pkg::BT_RDWR) ? (acc.kind == bdu_pkg::ACC_READ ||
                                                     acc.kind == bdu_pkg::ACC_WRITE) :
                    1'b0;

   assign hit = acc.valid && word_eq && overlap && kind_ok;
endmodule

/* File: verilog/breakpoint_debug_unit.sv */
// breakpoint debug unit: four address breakpoints, control, status, interrupt
// assumes core access ports synchronous to REF_CLK and an AHB-Lite single slave
`timescale 1ns/1ps
`include "bdu_defs.svh"

module breakpoint_debug_unit #(
   parameter int NUM_BP = 4
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // ahb-lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [3:0] HPROT,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // core access to compare
   input wire logic ACC_VALID,
   input wire logic [31:0] ACC_ADDR,
   input wire bdu_pkg::acc_kind_t ACC_KIND,
   input wire bdu_pkg::bp_len_t ACC_SIZE,
   input wire logic TASK_SWITCH,
   // exception to the core
   output logic DBG_EXC,
   output logic DBG_EXC_FETCH,
   output logic [3:0] DBG_HITS,
   // interrupt
   output logic IRQ
);
   // state
   logic [31:0] bp_addr_q [NUM_BP];
   logic [31:0] ctrl_q;
   logic [3:0] stat_q;
   logic [1:0] irq_stat_q;
   logic [1:0] irq_en_q;
   logic wr_pend_q;
   logic [7:0] wr_ofs_q;
   logic [31:0] rdata_q;
   logic exc_q;
   logic exc_fetch_q;
   logic irq_q;

   // next values
   logic [31:0] ctrl_d;
   logic [3:0] stat_d;
   logic [1:0] irq_stat_d;

   // bus decode
   wire addr_phase;
   wire privileged;
   wire allowed;
   wire refused;
   wire [7:0] ofs;
   wire wr_ctrl;
   wire wr_irqclr;
   wire wr_irqen;
   wire [31:0] rd_val;

   // comparison
   wire [NUM_BP-1:0] hit;
   wire [NUM_BP-1:0] bp_en;
   wire exc_d;
   wire fetch_exc_d;

   access_if acc ();

   assign acc.valid = ACC_VALID;
   assign acc.addr = ACC_ADDR;
   assign acc.kind = ACC_KIND;
   assign acc.size = ACC_SIZE;

   genvar n;
   generate
      for (n = 0; n < NUM_BP; n++) begin : g_bp
         bp_compare u_cmp (
            .bp_addr (bp_addr_q[n]),
            .bp_type (bdu_pkg::bp_type_t'(ctrl_q[`BDU_CTL_TYPE+4*n +: 2])),
            .bp_len  (bdu_pkg::bp_len_t'(ctrl_q[`BDU_CTL_LEN+4*n +: 2])),
            .acc     (acc),
            .hit     (hit[n])
         );
         // either enable arms the breakpoint
         assign bp_en[n] = ctrl_q[`BDU_CTL_LOC+2*n] | ctrl_q[`BDU_CTL_GLB+2*n];
      end
   endgenerate

   assign exc_d = |(hit & bp_en);
   // fetch breakpoints are flagged so the core squashes the instruction
   assign fetch_exc_d = exc_d && (ACC_KIND == bdu_pkg::ACC_FETCH);

   // address phase and privilege check; hprot[1] marks a privileged access
   assign addr_phase = HSEL && HTRANS[1] && HREADY;
   assign privileged = HPROT[1];
   assign allowed = privileged && !ctrl_q[`BDU_CTL_GD];
   assign refused = addr_phase && !allowed;
   assign ofs = {HADDR[7:2], 2'b00};

   assign wr_ctrl = wr_pend_q && (wr_ofs_q == `BDU_OFS_DCTRL);
   assign wr_irqclr = wr_pend_q && (wr_ofs_q == `BDU_OFS_IRQCLR);
   assign wr_irqen = wr_pend_q && (wr_ofs_q == `BDU_OFS_IRQEN);

   // read mux; the clear register and unmapped words read zero
   assign rd_val = (ofs == `BDU_OFS_BPADDR0) ? bp_addr_q[0] :
                   (ofs == `BDU_OFS_BPADDR1) ? bp_addr_q[1] :
                   (ofs == `BDU_OFS_BPADDR2) ? bp_addr_q[2] :
                   (ofs == `BDU_OFS_BPADDR3) ? bp_addr_q[3] :
                   (ofs == `BDU_OFS_DSTAT) ? (`BDU_STAT_ONES | {28'h0, stat_q}) :
                   (ofs == `BDU_OFS_DCTRL) ? (`BDU_CTL_ONES | ctrl_q) :
                   (ofs == `BDU_OFS_IRQSTAT) ? {30'h0, irq_stat_q} :
                   (ofs == `BDU_OFS_IRQEN) ? {30'h0, irq_en_q} :
                   32'h0000_0000;

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = HWDATA & `BDU_CTL_WMASK;
      end
      // task switch drops local enables, globals stay
      if (TASK_SWITCH) begin
         ctrl_d = ctrl_d & ~`BDU_CTL_LOCMASK;
      end
      // an exception reopens register access
      if (exc_d) begin
         ctrl_d[`BDU_CTL_GD] = 1'b0;
      end
   end

   always_comb begin
      // status has no software write path; an interrupt clear with the exception bit set empties it
      stat_d = stat_q;
      if (wr_irqclr && HWDATA[`BDU_IRQ_EXC]) begin
         stat_d = `BDU_RST_STAT;
      end
      // met conditions are recorded, enabled or not, only in a cycle where an enabled breakpoint hits; set beats clear
      if (exc_d) begin
         stat_d = stat_d | hit;
      end
   end

   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_irqclr) begin
         irq_stat_d = irq_stat_q & ~HWDATA[1:0];
      end
      irq_stat_d[`BDU_IRQ_EXC] = irq_stat_d[`BDU_IRQ_EXC] | exc_d;
      irq_stat_d[`BDU_IRQ_REFUSED] = irq_stat_d[`BDU_IRQ_REFUSED] | refused;
   end

   // bus side: zero wait states, always okay
   // hsize is not checked; software is expected to move whole words only
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_q <= 1'b0;
         wr_ofs_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_phase && HWRITE && allowed;
         wr_ofs_q <= ofs;
         rdata_q <= (addr_phase && !HWRITE && allowed) ? rd_val : 32'h0000_0000;
      end
   end

   // breakpoint addresses, one word each
   generate
      for (n = 0; n < NUM_BP; n++) begin : g_addr
         always_ff @(posedge REF_CLK or negedge RST_N) begin
            if (!RST_N) begin
               bp_addr_q[n] <= `BDU_RST_ADDR;
            end else if (wr_pend_q && wr_ofs_q == 8'(4*n)) begin
               bp_addr_q[n] <= HWDATA;
            end
         end
      end
   endgenerate

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_q <= `BDU_RST_CTRL;
         stat_q <= `BDU_RST_STAT;
         irq_stat_q <= 2'h0;
         irq_en_q <= 2'h0;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= wr_irqen ? HWDATA[1:0] : irq_en_q;
      end
   end

   // exception one cycle after the access, ahead of execute
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         exc_q <= 1'b0;
         exc_fetch_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         exc_q <= exc_d;
         exc_fetch_q <= fetch_exc_d;
         // enable as it stood; a fresh enable reaches the pin one cycle later
         irq_q <= |(irq_stat_d & irq_en_q);
      end
   end

   assign HRDATA = rdata_q;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign DBG_EXC = exc_q;
   assign DBG_EXC_FETCH = exc_fetch_q;
   assign DBG_HITS = stat_q;
   assign IRQ = irq_q;

   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   exc_on_hit_a: assert property (ACC_VALID && |(hit & bp_en) |=> DBG_EXC)
      else $error("enabled breakpoint hit without exception");

   no_exc_disabled_a: assert property (!(|(hit & bp_en)) |=> !DBG_EXC)
      else $error("exception without an enabled hit");

   fetch_before_a: assert property (exc_d && ACC_KIND == bdu_pkg::ACC_FETCH
                                    |=> DBG_EXC && DBG_EXC_FETCH)
      else $error("fetch breakpoint not flagged before execute");

   hits_recorded_a: assert property (exc_d |=> (DBG_HITS & $past(hit)) == $past(hit))
      else $error("met condition missing from status");

   status_ro_a: assert property (wr_pend_q && wr_ofs_q == `BDU_OFS_DSTAT && !exc_d
                                 |=> $stable(stat_q))
      else $error("status changed by a write");

   local_drop_a: assert property (TASK_SWITCH |=> (ctrl_q & `BDU_CTL_LOCMASK) == 32'h0)
      else $error("local enable kept across task switch");

   global_keep_a: assert property (TASK_SWITCH && !wr_ctrl
                                   |=> ctrl_q[`BDU_CTL_GLB] == $past(ctrl_q[`BDU_CTL_GLB]))
      else $error("global enable lost on task switch");

   unpriv_ignored_a: assert property (addr_phase && HWRITE && !privileged
                                      |=> !wr_pend_q ##1 $stable(ctrl_q[15:0]))
      else $error("unprivileged write took effect");

   addr_write_a: assert property (wr_pend_q && wr_ofs_q == `BDU_OFS_BPADDR0
                                  |=> bp_addr_q[0] == $past(HWDATA))
      else $error("breakpoint address not stored");

   type_unused_a: assert property (ctrl_q[`BDU_CTL_TYPE+12 +: 2] == 2'h2 |-> !hit[3])
      else $error("unused type matched");

   len_unused_a: assert property (ctrl_q[`BDU_CTL_LEN +: 2] == 2'h2 |-> !hit[0])
      else $error("unused length matched");

   word_cover_a: assert property (ACC_VALID && ACC_ADDR[31:2] == bp_addr_q[2][31:2]
                                  && ctrl_q[`BDU_CTL_LEN+8 +: 2] == 2'h3
                                  && ctrl_q[`BDU_CTL_TYPE+8 +: 2] == 2'h3
                                  && (ACC_KIND == bdu_pkg::ACC_READ
                                      || ACC_KIND == bdu_pkg::ACC_WRITE)
                                  && ACC_SIZE != bdu_pkg::LEN_X |-> hit[2])
      else $error("four-byte breakpoint missed an access in its word");

   // a refused access must leave its trace for software
   refuse_flag_a: assert property (refused |=> irq_stat_q[`BDU_IRQ_REFUSED])
      else $error("refused access not flagged");

   gd_clear_a: assert property (exc_d |=> !ctrl_q[`BDU_CTL_GD])
      else $error("exception left register access closed");

   rdata_idle_a: assert property (!(addr_phase && !HWRITE && allowed) |=> HRDATA == 32'h0)
      else $error("read data outside a read data phase");

   fetch_only_a: assert property (DBG_EXC_FETCH |-> DBG_EXC)
      else $error("fetch flag without an exception");

   exc_seen_c: cover property (ACC_VALID && exc_d ##1 DBG_EXC);
   gd_reopen_c: cover property (exc_d && ctrl_q[`BDU_CTL_GD]);
   fetch_seen_c: cover property (fetch_exc_d);
   disabled_hit_c: cover property (exc_d && (hit & ~bp_en) != 4'h0);
   refused_c: cover property (refused && HWRITE);
endmodule
